// *** pkg/sasp_regs.vh ***
// constants for the stereo adc audio serial port
// Behaviour
// - role strap low selects bus slave
// - role strap high selects bus master
// - slave: host drives frame sync, bit clock
// - master: device drives frame sync, bit clock
// - format strap low: two-channel i2s
// - format strap high: two-channel tdm
// - each sample 32 bits, msb first
// - master needs 256 or 512 fs sysclk
// - slave accepts up to 192 khz frames
// - clocks stop: power down, resume later
// - range boost only in slave operation
// - filter choice only in slave operation
// - tdm: frame_sync rise starts slot 0
// - i2s: msb second falling edge after frame_sync
// - extra bit clocks carry zeros
`ifndef SASP_REGS_VH
`define SASP_REGS_VH
// word length and channel count
`define SASP_WORD_BITS 32
`define SASP_CHANNELS 2
// master clock ratios (system clock cycles per frame)
`define SASP_RATIO_LO 256
`define SASP_RATIO_HI 512
// clock-loss timeout, in ns, and cycles at 4 ns
`define SASP_LOSS_NS 2000
`define SASP_CLK_NS 4
`define SASP_LOSS_CYC (`SASP_LOSS_NS / `SASP_CLK_NS)
`endif

// *** hw/sasp_fifo.v ***
// sample fifo for the audio serial port
`timescale 1ns/1ps
module sasp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  // storage and pointers
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0] cnt_ff;
  wire do_wr;
  wire do_rd;
  assign in_ready_out = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_out = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_out = mem_ff[rd_ff];
  assign do_wr = in_valid_in & in_ready_out;
  assign do_rd = out_valid_out & out_ready_in;
  // ===========================================
  // storage write
  always @(posedge clk_in)
  begin
    if (do_wr)
    begin
      mem_ff[wr_ff] <= in_data_in;
    end
  end
  // pointers and occupancy
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (do_rd)
      begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (do_wr & ~do_rd)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (do_rd & ~do_wr)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // sasp_fifo

// *** hw/sasp_top.v ***
// audio serial port of a stereo adc: strap decode, master clocks, serialiser
`timescale 1ns/1ps
`include "sasp_regs.vh"
module sasp_top #(
  parameter LOSS_CYC = `SASP_LOSS_CYC,
  parameter FIFO_DEPTH = 32
) (
  // system clock and reset
  input wire CLK_SYS_IN,
  input wire SYS_RST_IN,
  // strap pins
  input wire ROLE_SELECT_PIN_IN,
  input wire FORMAT_SELECT_PIN_IN,
  input wire MODE_SELECT_PIN_A_IN,
  input wire MODE_SELECT_PIN_B_IN,
  input wire RATIO_512_IN,
  // bit clock pin
  input wire BIT_CLOCK_IN,
  output reg BIT_CLOCK_OUT,
  output reg BIT_CLOCK_OE_OUT,
  // frame sync pin
  input wire FRAME_SYNC_IN,
  output reg FRAME_SYNC_OUT,
  output reg FRAME_SYNC_OE_OUT,
  // serial data out
  output reg SERIAL_DATA_OUT,
  // sample stream from the converter
  input wire SAMPLE_VALID_IN,
  output reg SAMPLE_READY_OUT,
  input wire [`SASP_WORD_BITS-1:0] SAMPLE_DATA_IN,
  // status
  output reg MASTER_OUT,
  output reg TDM_OUT,
  output reg POWER_DOWN_OUT,
  output reg RANGE_BOOST_EN_OUT,
  output reg LOW_LATENCY_EN_OUT
);
  // ===========================================
  // pin synchronisers
  reg [1:0] bclk_sy_ff;
  reg [1:0] fs_sy_ff;
  reg bclk_d_ff;
  reg fs_d_ff;
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      bclk_sy_ff <= 2'h0;
      fs_sy_ff <= 2'h0;
      bclk_d_ff <= 1'b0;
      fs_d_ff <= 1'b0;
    end
    else
    begin
      bclk_sy_ff <= {bclk_sy_ff[0], BIT_CLOCK_IN};
      fs_sy_ff <= {fs_sy_ff[0], FRAME_SYNC_IN};
      bclk_d_ff <= bclk_sy_ff[1];
      fs_d_ff <= fs_sy_ff[1];
    end
  end
  // ===========================================
  // strap synchronisers, read only while powered down
  reg [4:0] strap_a_ff;
  reg [4:0] strap_b_ff;
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      strap_a_ff <= 5'h00;
      strap_b_ff <= 5'h00;
    end
    else
    begin
      strap_a_ff <= {RATIO_512_IN, MODE_SELECT_PIN_B_IN, MODE_SELECT_PIN_A_IN,
                     FORMAT_SELECT_PIN_IN, ROLE_SELECT_PIN_IN};
      strap_b_ff <= strap_a_ff;
    end
  end
  // ===========================================
  // configuration, latched in power-down only
  reg master_ff;
  reg tdm_ff;
  reg ratio_ff;
  reg boost_ff;
  reg lowlat_ff;
  reg pd_ff;
  reg [15:0] loss_ff;
  // bit clock edges seen in this domain
  wire in_rise = bclk_sy_ff[1] & ~bclk_d_ff;
  wire in_fall = ~bclk_sy_ff[1] & bclk_d_ff;
  // master clock generator state
  reg [8:0] div_ff;
  wire [8:0] half = ratio_ff ? 9'h0ff : 9'h07f;
  wire m_rise = master_ff & ~pd_ff & (div_ff == half);
  wire m_fall = master_ff & ~pd_ff & (div_ff == 9'h000);
  wire rise = master_ff ? m_rise : in_rise;
  wire fall = master_ff ? m_fall : in_fall;
  // activity seen: any bit clock edge, or master always running
  wire activity = in_rise | in_fall | master_ff;
  // clock-loss detection and strap capture
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      pd_ff <= 1'b1;
      loss_ff <= 16'h0000;
      master_ff <= 1'b0;
      tdm_ff <= 1'b0;
      ratio_ff <= 1'b0;
      boost_ff <= 1'b0;
      lowlat_ff <= 1'b0;
    end
    else
    begin
      if (pd_ff)
      begin
        // straps sampled while powered down
        master_ff <= strap_b_ff[0]; // low slave, high master
        tdm_ff <= strap_b_ff[1];
        ratio_ff <= strap_b_ff[4];
        boost_ff <= strap_b_ff[2] & ~strap_b_ff[0];
        lowlat_ff <= strap_b_ff[3] & ~strap_b_ff[0];
        // leave power-down at once as master, on a bit clock rise as slave
        if (strap_b_ff[0] | in_rise)
        begin
          pd_ff <= 1'b0;
        end
        loss_ff <= 16'h0000;
      end
      else if (activity)
      begin
        loss_ff <= 16'h0000;
      end
      else if (loss_ff == LOSS_CYC[15:0] - 16'h0001)
      begin
        pd_ff <= 1'b1; // clocks stopped: power down
      end
      else
      begin
        loss_ff <= loss_ff + 16'h0001;
      end
    end
  end
  // ===========================================
  // master divider: bit clock = sysclk / ratio * 64, frame = 64 bits
  reg [5:0] mbit_ff;
  reg m_bclk_ff;
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      div_ff <= 9'h000;
      m_bclk_ff <= 1'b0;
      mbit_ff <= 6'h00;
    end
    else if (~master_ff | pd_ff)
    begin
      div_ff <= 9'h000;
      m_bclk_ff <= 1'b0;
      mbit_ff <= 6'h00;
    end
    else
    begin
      // 64 bit clocks per frame of 256 or 512 sysclk cycles: toggle every 2 or 4
      div_ff <= (div_ff == half) ? 9'h000 : div_ff + 9'h001;
      if (ratio_ff ? (div_ff[1:0] == 2'h1) : (div_ff[0] == 1'b1))
      begin
        m_bclk_ff <= ~m_bclk_ff;
        if (m_bclk_ff)
        begin
          mbit_ff <= mbit_ff + 6'h01;
        end
      end
    end
  end
  // ===========================================
  // serial frame engine
  // bit clock edges used by the engine (master uses its own divider phases)
  wire m_tog = ratio_ff ? (div_ff[1:0] == 2'h1) : (div_ff[0] == 1'b1);
  wire e_rise = master_ff ? (m_tog & ~m_bclk_ff & ~pd_ff) : in_rise;
  wire e_fall = master_ff ? (m_tog & m_bclk_ff & ~pd_ff) : in_fall;
  // frame sync level as the engine sees it
  wire fs_now = master_ff ? FRAME_SYNC_OUT : fs_d_ff;
  reg fs_last_ff;
  reg [6:0] bit_ff;
  reg [`SASP_WORD_BITS-1:0] shift_ff;
  reg [1:0] chan_ff;
  wire f_valid;
  wire [`SASP_WORD_BITS-1:0] f_data;
  reg f_take;
  wire f_ready;
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      fs_last_ff <= 1'b0;
      bit_ff <= 7'h7f;
      shift_ff <= 32'h00000000;
      chan_ff <= 2'h0;
      f_take <= 1'b0;
      SERIAL_DATA_OUT <= 1'b0;
      FRAME_SYNC_OUT <= 1'b0;
    end
    else
    begin
      f_take <= 1'b0;
      if (pd_ff)
      begin
        bit_ff <= 7'h7f;
        SERIAL_DATA_OUT <= 1'b0;
        FRAME_SYNC_OUT <= 1'b0;
        chan_ff <= 2'h0;
      end
      else if (e_rise)
      begin
        // master frame sync changes on rising edges
        if (master_ff)
        begin
          FRAME_SYNC_OUT <= tdm_ff ? (mbit_ff == 6'h3f) : ~mbit_ff[5];
        end
        if (tdm_ff)
        begin
          fs_last_ff <= fs_now;
          if (fs_now & ~fs_last_ff)
          begin
            // frame start: slot 0 msb out
            bit_ff <= 7'h01;
            chan_ff <= 2'h1;
            SERIAL_DATA_OUT <= f_valid ? f_data[31] : 1'b0;
            shift_ff <= f_valid ? {f_data[30:0], 1'b0} : 32'h00000000;
            f_take <= f_valid;
          end
          else if (bit_ff < 7'h40)
          begin
            // next bit, slot 1 follows slot 0
            if (bit_ff == 7'h20)
            begin
              SERIAL_DATA_OUT <= f_valid ? f_data[31] : 1'b0;
              shift_ff <= f_valid ? {f_data[30:0], 1'b0} : 32'h00000000;
              f_take <= f_valid;
            end
            else
            begin
              SERIAL_DATA_OUT <= shift_ff[31];
              shift_ff <= {shift_ff[30:0], 1'b0};
            end
            bit_ff <= bit_ff + 7'h01;
          end
          else
          begin
            SERIAL_DATA_OUT <= 1'b0; // unused bit clocks carry zero
          end
        end
      end
      else if (e_fall & ~tdm_ff)
      begin
        // i2s: msb in second cycle after each frame_sync edge
        fs_last_ff <= fs_now;
        if (fs_now != fs_last_ff)
        begin
          // sync edge seen one fall late: msb goes out now, lsb not lost
          SERIAL_DATA_OUT <= f_valid ? f_data[31] : 1'b0;
          shift_ff <= f_valid ? {f_data[30:0], 1'b0} : 32'h00000000;
          f_take <= f_valid;
          bit_ff <= 7'h01;
        end
        else if (bit_ff < 7'h20)
        begin
          SERIAL_DATA_OUT <= shift_ff[31];
          shift_ff <= {shift_ff[30:0], 1'b0};
          bit_ff <= bit_ff + 7'h01;
        end
        else
        begin
          SERIAL_DATA_OUT <= 1'b0; // extra bit clocks zero
        end
      end
    end
  end
  // ===========================================
  // sample buffer between converter and serialiser
  sasp_fifo #(
    .WIDTH(`SASP_WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_in(SYS_RST_IN),
    .in_valid_in(SAMPLE_VALID_IN & ~pd_ff),
    .in_ready_out(f_ready),
    .in_data_in(SAMPLE_DATA_IN),
    .out_valid_out(f_valid),
    .out_ready_in(f_take),
    .out_data_out(f_data)
  );
  // ===========================================
  // registered outputs and pin drivers
  always @(posedge CLK_SYS_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      BIT_CLOCK_OUT <= 1'b0;
      BIT_CLOCK_OE_OUT <= 1'b0;
      FRAME_SYNC_OE_OUT <= 1'b0;
      SAMPLE_READY_OUT <= 1'b0;
      MASTER_OUT <= 1'b0;
      TDM_OUT <= 1'b0;
      POWER_DOWN_OUT <= 1'b1;
      RANGE_BOOST_EN_OUT <= 1'b0;
      LOW_LATENCY_EN_OUT <= 1'b0;
    end
    else
    begin
      BIT_CLOCK_OUT <= m_bclk_ff;
      BIT_CLOCK_OE_OUT <= master_ff & ~pd_ff;
      FRAME_SYNC_OE_OUT <= master_ff & ~pd_ff;
      SAMPLE_READY_OUT <= f_ready & ~pd_ff;
      MASTER_OUT <= master_ff;
      TDM_OUT <= tdm_ff;
      POWER_DOWN_OUT <= pd_ff;
      RANGE_BOOST_EN_OUT <= boost_ff & ~master_ff;
      LOW_LATENCY_EN_OUT <= lowlat_ff & ~master_ff;
    end
  end
endmodule // sasp_top

// *** tb/sasp_top_asserts.sv ***
// checker bound to the audio serial port top
`timescale 1ns/1ps
module sasp_top_asserts (
  // clock and reset
  input wire CLK_SYS_IN,
  input wire SYS_RST_IN,
  // pins and status
  input wire RATIO_512_IN,
  input wire BIT_CLOCK_IN,
  input wire BIT_CLOCK_OUT,
  input wire BIT_CLOCK_OE_OUT,
  input wire FRAME_SYNC_OUT,
  input wire FRAME_SYNC_OE_OUT,
  input wire SERIAL_DATA_OUT,
  input wire MASTER_OUT,
  input wire TDM_OUT,
  input wire POWER_DOWN_OUT,
  input wire RANGE_BOOST_EN_OUT,
  input wire LOW_LATENCY_EN_OUT
);
  // ====================
  // one clock domain
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // ====================
  // pin direction and options
  property p_slv;
    !MASTER_OUT |-> !BIT_CLOCK_OE_OUT && !FRAME_SYNC_OE_OUT;
  endproperty
  a_slv: assert property (p_slv) else $error("slave drives clocks");
  property p_mst;
    (MASTER_OUT && !POWER_DOWN_OUT) [*3] |-> BIT_CLOCK_OE_OUT && FRAME_SYNC_OE_OUT;
  endproperty
  a_mst: assert property (p_mst) else $error("master clocks idle");
  property p_fix;
    !POWER_DOWN_OUT && !$past(POWER_DOWN_OUT) |-> $stable({MASTER_OUT, TDM_OUT});
  endproperty
  a_fix: assert property (p_fix) else $error("straps moved");
  property p_opt;
    RANGE_BOOST_EN_OUT || LOW_LATENCY_EN_OUT |-> !MASTER_OUT;
  endproperty
  a_opt: assert property (p_opt) else $error("option in master");
  // ====================
  // master clock shapes: bit clock at 256 ratio, tdm sync pulse at 512 ratio
  property p_bck;
    MASTER_OUT && !RATIO_512_IN && $rose(BIT_CLOCK_OUT)
      |-> BIT_CLOCK_OUT [*2] ##1 !BIT_CLOCK_OUT [*2] ##1 BIT_CLOCK_OUT;
  endproperty
  a_bck: assert property (p_bck) else $error("bit clock shape");
  property p_fsp;
    MASTER_OUT && TDM_OUT && RATIO_512_IN && $rose(FRAME_SYNC_OUT)
      |-> FRAME_SYNC_OUT [*8] ##1 !FRAME_SYNC_OUT;
  endproperty
  a_fsp: assert property (p_fsp) else $error("sync pulse width");
  // ====================
  // slave data moves only after the launching edge
  property p_sdt;
    !MASTER_OUT && TDM_OUT && !POWER_DOWN_OUT && $changed(SERIAL_DATA_OUT)
      |-> $past(BIT_CLOCK_IN, 2);
  endproperty
  a_sdt: assert property (p_sdt) else $error("tdm data edge");
  property p_sdi;
    !MASTER_OUT && !TDM_OUT && !POWER_DOWN_OUT && $changed(SERIAL_DATA_OUT)
      |-> !$past(BIT_CLOCK_IN, 2);
  endproperty
  a_sdi: assert property (p_sdi) else $error("i2s data edge");
  c_tdm: cover property (!MASTER_OUT && TDM_OUT && $changed(SERIAL_DATA_OUT));
  c_i2s: cover property (!MASTER_OUT && !TDM_OUT && $changed(SERIAL_DATA_OUT));
  c_mst: cover property (MASTER_OUT && $rose(FRAME_SYNC_OUT));
endmodule // sasp_top_asserts
bind sasp_top sasp_top_asserts u_chk (.*);

// *** tb/sasp_host.sv ***
// host model: makes bit clock and frame sync, shifts in the data line
`timescale 1ns/1ps
module sasp_host (
  // pins toward the device
  output logic bclk_out,
  output logic fs_out,
  input wire sd_in
);
  // last frame: 64 data bits, then 8 spare
  logic [71:0] got;
  initial
  begin
    bclk_out = 1'h0;
    fs_out = 1'h1;
    got = 72'h0;
  end
  // ====================
  // one frame of 74 bit clocks, clock stands still after it
  task automatic frame(input logic tdm);
    int c;
    begin
      for (c = 0; c < 74; c++) // more bit clocks than 64
      begin
        if (!tdm && c > 1)
          got = {got[70:0], sd_in}; // i2s bit held over the fall
        bclk_out = 1'h0;
        fs_out = tdm ? (c == 0) : (c > 31); // host drives sync
        #16;
        bclk_out = 1'h1;
        if (tdm && c > 0 && c < 73)
          got = {got[70:0], sd_in}; // tdm bit held over the rise
        #16;
      end
      bclk_out = 1'h0;
    end
  endtask
endmodule // sasp_host

// *** tb/sasp_top_tb.sv ***
// self-checking bench for the audio serial port top
`timescale 1ns/1ps
module sasp_top_tb;
  // straps set by the bench, changed before each clock-loss power-down and between resets
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic role = 1'h0;
  logic fmt = 1'h1;
  logic mda = 1'h0;
  logic mdb = 1'h0;
  logic r512 = 1'h0;
  logic sv = 1'h0;
  logic [31:0] sdat = 32'h0;
  wire hb, hf, bo, boe, fo, foe, sd, rdy, mst, tdm, pd, boost, lowl;
  // shared pin levels
  wire bw = boe ? bo : hb;
  wire fw = foe ? fo : hf;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int i, j, nb, nf;
  logic pb, pf;
  logic [31:0] lw, rw;
  logic [66:0] rows [4];
  always #2 clk = ~clk;
  sasp_top #(.LOSS_CYC(100)) dut (
    .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .ROLE_SELECT_PIN_IN(role),
    .FORMAT_SELECT_PIN_IN(fmt), .MODE_SELECT_PIN_A_IN(mda), .MODE_SELECT_PIN_B_IN(mdb),
    .RATIO_512_IN(r512), .BIT_CLOCK_IN(bw), .BIT_CLOCK_OUT(bo), .BIT_CLOCK_OE_OUT(boe),
    .FRAME_SYNC_IN(fw), .FRAME_SYNC_OUT(fo), .FRAME_SYNC_OE_OUT(foe),
    .SERIAL_DATA_OUT(sd), .SAMPLE_VALID_IN(sv), .SAMPLE_READY_OUT(rdy),
    .SAMPLE_DATA_IN(sdat), .MASTER_OUT(mst), .TDM_OUT(tdm), .POWER_DOWN_OUT(pd),
    .RANGE_BOOST_EN_OUT(boost), .LOW_LATENCY_EN_OUT(lowl)
  );
  sasp_host host (.bclk_out(hb), .fs_out(hf), .sd_in(sd));
  // ====================
  // helpers
  task automatic chk(input string nm, input logic [71:0] seen, input logic [71:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task automatic push(input logic [31:0] w);
    begin
      @(negedge clk);
      sv = 1'h1;
      sdat = w;
      @(negedge clk);
      sv = 1'h0;
    end
  endtask
  task automatic stop_test;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end
  // ====================
  // main sequence
  initial
  begin
    rows[0] = {1'h1, 1'h1, 1'h0, 32'h8000_0001, 32'h7fff_fffe};
    rows[1] = {1'h0, 1'h0, 1'h1, 32'h8000_0001, 32'h7fff_fffe};
    rows[2] = {1'h1, 1'h0, 1'h0, 32'hffff_ffff, 32'h0000_0000};
    rows[3] = {1'h0, 1'h1, 1'h1, 32'ha5a5_5a5a, 32'h0000_0001};
    repeat (20) @(negedge clk);
    chk("reset", {pd, mst, tdm, boe, foe, rdy, sd}, 72'h40);
    rst = 1'h0;
    // table rows: clock loss, new straps, one stereo frame
    for (i = 0; i < 4; i++)
    begin
      {fmt, mda, mdb, lw, rw} = rows[i];
      repeat (140) @(negedge clk);
      chk("pdown", pd, 72'h1);
      host.frame(fmt);
      chk("idle", host.got, 72'h0);
      chk("mode", {pd, mst, boe, foe, tdm, boost, lowl}, {fmt, mda, mdb});
      push(lw);
      push(rw);
      host.frame(fmt);
      chk("frame", host.got, {lw, rw, 8'h00});
    end
    // fill past full, then drain frame by frame
    for (i = 0; i < 33; i++)
      push(32'h1000_0000 + i);
    chk("full", rdy, 72'h0);
    for (i = 0; i < 17; i++)
    begin
      host.frame(fmt);
      lw = 32'h1000_0000 + 2 * i;
      chk("drain", host.got, (i < 16) ? {lw, lw + 32'h1, 8'h00} : 72'h0);
    end
    chk("ready", rdy, 72'h1);
    // master with both ratios, options requested but refused
    role = 1'h1;
    mda = 1'h1;
    mdb = 1'h1;
    for (j = 0; j < 2; j++)
    begin
      r512 = j[0];
      fmt = j[0];
      rst = 1'h1;
      repeat (20) @(negedge clk);
      rst = 1'h0;
      repeat (40) @(negedge clk);
      chk("master", {mst, boe, foe, boost, lowl}, 72'h1c);
      nb = 0;
      nf = 0;
      pb = bo;
      pf = fo;
      repeat (1024 << j)
      begin
        @(negedge clk);
        nb += (bo && !pb);
        nf += (fo && !pf);
        pb = bo;
        pf = fo;
      end
      chk("clocks", {nb[15:0], nf[15:0]}, {16'h0100, 16'h0004});
    end
    stop_test();
  end
endmodule // sasp_top_tb
